// ==== src/itvd_map.svh ====
// itvd_map.svh: offsets, field positions, reset values and vector constants
// assumes: included by the interrupt dispatch design files and the dispatch assertion checker
`ifndef ITVD_MAP_SVH
`define ITVD_MAP_SVH
// register byte offsets on the bus
`define ITVD_OFF_SRC_BASE 12'h000
`define ITVD_OFF_PSW 12'h080
`define ITVD_OFF_TFR 12'h084
`define ITVD_OFF_LAST 12'h088
`define ITVD_OFF_CHN_BASE 12'h0a0
// source control register fields
`define ITVD_ICR_REQ_BIT 7
`define ITVD_ICR_EN_BIT 6
`define ITVD_ICR_LVL_LSB 2
`define ITVD_ICR_GRP_LSB 0
`define ITVD_ICR_RESET 8'h00
// status word fields
`define ITVD_PSW_LVL_LSB 0
`define ITVD_PSW_IEN_BIT 4
`define ITVD_PSW_RESET 5'h00
// trap flag register: class a in low bits, class b above
`define ITVD_TFR_NMI_BIT 0
`define ITVD_TFR_STKOF_BIT 1
`define ITVD_TFR_STKUF_BIT 2
`define ITVD_TFR_B_LSB 3
`define ITVD_TFR_RESET 8'h00
// channel control: transfer count and byte mode
`define ITVD_CHN_CNT_LSB 0
`define ITVD_CHN_BYTE_BIT 8
`define ITVD_CHN_RESET 9'h000
// hardware trap vectors and source numbering
`define ITVD_VEC_NMI 16'h0008
`define ITVD_VEC_STKOF 16'h0010
`define ITVD_VEC_STKUF 16'h0018
`define ITVD_VEC_CLASSB 16'h0028
`define ITVD_SRC_TRAPNUM_BASE 7'h10
`define ITVD_SER0_ERR_IDX 5'h1c
`define ITVD_SER1_ERR_IDX 5'h1f
// the two top levels are the only ones that may use a channel
`define ITVD_PEC_LVL_LO 4'he
`endif

// ==== src/itvd_pkg.sv ====
// itvd_pkg: types shared by the interrupt dispatch design
// assumes: used as itvd_pkg::name, never imported
package itvd_pkg;
  // one source control register
  typedef struct packed {
    logic req;
    logic en;
    logic [3:0] lvl;
    logic [1:0] grp;
  } itvd_icr_t;

  typedef enum logic [2:0] {
    ITVD_K_NONE,
    ITVD_K_INT,
    ITVD_K_PEC,
    ITVD_K_HWTRAP,
    ITVD_K_SWTRAP
  } itvd_kind_t;

  // one dispatch toward the cpu core
  typedef struct packed {
    logic valid;
    itvd_kind_t kind;
    logic [15:0] vector;
    logic push_status;
    logic [2:0] channel;
    logic byte_mode;
    logic [3:0] level;
  } itvd_disp_t;

  typedef enum logic {
    ITVD_ST_RUN,
    ITVD_ST_PEC
  } itvd_state_t;
endpackage : itvd_pkg

// ==== src/itvd_src_ctrl.sv ====
// itvd_src_ctrl: one source control register with request, enable, level
// assumes: write strobe from the bus slave, clear from the dispatcher
`timescale 1ns/10ps
`include "itvd_map.svh"
module itvd_src_ctrl (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  input wire logic set_evt,
  input wire logic clr_serv,
  output itvd_pkg::itvd_icr_t icr
);
  itvd_pkg::itvd_icr_t icr_r;

  ////////////////////////////////////////////////////////////////////////
  // request flag: a hardware set wins over any clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      icr_r <= itvd_pkg::itvd_icr_t'(`ITVD_ICR_RESET);
    end else begin
      if (wr_en) begin
        icr_r.en <= wr_data[`ITVD_ICR_EN_BIT];
        icr_r.lvl <= wr_data[`ITVD_ICR_LVL_LSB +: 4];
        icr_r.grp <= wr_data[`ITVD_ICR_GRP_LSB +: 2];
      end
      if (set_evt) begin
        icr_r.req <= 1'b1;
      end else if (wr_en) begin
        icr_r.req <= wr_data[`ITVD_ICR_REQ_BIT];
      end else if (clr_serv) begin
        icr_r.req <= 1'b0;
      end
    end
  end

  assign icr = icr_r;
endmodule : itvd_src_ctrl

// ==== src/itvd_dispatch.sv ====
// itvd_dispatch: interrupt, channel transfer and trap dispatch with ahb-lite slave
// assumes: one clock, round_tick marks each instruction cycle end,
// the core acts on disp and moves channel data itself
//
// What this block does
// - channel service moves one byte or word
// - eight programmable single transfer channels
// - channel transfer stalls cpu one cycle, no push
// - same arbitration, only two top levels transfer
// - nmi pin rising edge raises a hardware trap
// - hardware traps win at once over everything
// - software trap vectors by seven bit number
// - every trap entry pushes program status
// - each source owns control register and vector
// - one event sets request, serial errors ored
// - accepted request branches to fixed source vector
// - class b traps share vector, flags tell
// - jump table low in segment zero
// - sources numbered 10h to 2Fh, vector times four
// - serial 0 vectors A8h ACh B0h
// - serial 1 vectors B4h B8h BCh
// - flash write holds service, requests still latch
// - sixteen priority levels order requests
// - winner served only above cpu level
// - flag clears on service, stays at count zero
//
// Implementation choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/10ps
`include "itvd_map.svh"
module itvd_dispatch #(
  parameter int NSRC = 32,
  parameter int NCHN = 8,
  parameter int NCLSB = 5
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic round_tick,
  input wire logic [NSRC-1:0] src_event,
  input wire logic [2:0] ser0_err,
  input wire logic [2:0] ser1_err,
  input wire logic nmi_pin,
  input wire logic stk_ovf,
  input wire logic stk_unf,
  input wire logic [NCLSB-1:0] fault_b,
  input wire logic swtrap_valid,
  input wire logic [6:0] swtrap_num,
  input wire logic flash_busy,
  input wire logic flash_code_seg0,
  output itvd_pkg::itvd_disp_t disp,
  output logic cpu_stall
);
  localparam int SW = $clog2(NSRC);
  localparam int CW = $clog2(NCHN);

  // bus side state
  logic [11:0] a_r;
  logic wr_ph_r;
  logic rd_ph_r;
  logic hreadyout_r;
  logic [31:0] hrdata_r;
  // block state
  logic [3:0] psw_lvl_r;
  logic psw_ien_r;
  logic [7:0] tfr_r;
  logic [3:0] tpend_r;
  logic nmi_q_r;
  logic sw_pend_r;
  logic [6:0] sw_num_r;
  logic [8:0] chn_r [NCHN];
  itvd_pkg::itvd_disp_t disp_r;
  itvd_pkg::itvd_state_t state_r;
  // combinational
  itvd_pkg::itvd_icr_t icr [NSRC];
  logic [NSRC-1:0] ev;
  logic [NSRC-1:0] wr_src;
  logic [NSRC-1:0] clr_src;
  logic found;
  logic [SW-1:0] best_idx;
  logic [3:0] best_lvl;
  logic [1:0] best_grp;
  logic [CW-1:0] best_chn;
  logic serve;
  logic as_pec;
  logic hold_flash;
  logic addr_ph;
  logic wr_psw;
  logic wr_tfr;
  logic [NCHN-1:0] wr_chn;
  logic nmi_rise;
  logic [3:0] tset;
  logic hw_go;
  logic sw_go;
  logic [31:0] rdata;

  ////////////////////////////////////////////////////////////////////////
  // bus decode: address phase taken on hsel, nonseq/seq and hready
  assign addr_ph = hsel && htrans[1] && hready;
  assign wr_psw = wr_ph_r && (a_r == `ITVD_OFF_PSW);
  assign wr_tfr = wr_ph_r && (a_r == `ITVD_OFF_TFR);
  // write strobes per source and per channel
  always_comb begin
    wr_src = '0;
    wr_chn = '0;
    if (wr_ph_r && a_r[11:7] == 5'(`ITVD_OFF_SRC_BASE >> 7)) begin
      wr_src[a_r[SW+1:2]] = 1'b1;
    end
    if (wr_ph_r && a_r[11:5] == 7'(`ITVD_OFF_CHN_BASE >> 5)) begin
      wr_chn[a_r[CW+1:2]] = 1'b1;
    end
  end
  // address phase capture; reads take one wait state so data is fresh
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_r <= 12'h000;
      wr_ph_r <= 1'b0;
      rd_ph_r <= 1'b0;
      hreadyout_r <= 1'b1;
    end else begin
      wr_ph_r <= addr_ph && hwrite;
      rd_ph_r <= addr_ph && !hwrite;
      if (addr_ph) begin
        a_r <= haddr[11:0];
      end
      hreadyout_r <= !(addr_ph && !hwrite);
    end
  end

  // read mux over the latched address; unmapped reads return zero
  always_comb begin
    rdata = 32'h0000_0000;
    if (a_r[11:7] == 5'(`ITVD_OFF_SRC_BASE >> 7)) begin
      rdata[7:0] = icr[a_r[SW+1:2]];
    end else if (a_r[11:5] == 7'(`ITVD_OFF_CHN_BASE >> 5)) begin
      rdata[8:0] = chn_r[a_r[CW+1:2]];
    end else if (a_r == `ITVD_OFF_PSW) begin
      rdata[`ITVD_PSW_LVL_LSB +: 4] = psw_lvl_r;
      rdata[`ITVD_PSW_IEN_BIT] = psw_ien_r;
    end else if (a_r == `ITVD_OFF_TFR) begin
      rdata[7:0] = tfr_r;
    end else if (a_r == `ITVD_OFF_LAST) begin
      rdata[15:0] = disp_r.vector;
      rdata[18:16] = disp_r.kind;
    end
  end

  // read data registered in the wait cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h0000_0000;
    end else if (rd_ph_r) begin
      hrdata_r <= rdata;
    end
  end
  assign hrdata = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp = 1'b0; // always okay

  ////////////////////////////////////////////////////////////////////////
  // source control registers, one cell per source
  always_comb begin
    ev = src_event;
    ev[`ITVD_SER0_ERR_IDX] = src_event[`ITVD_SER0_ERR_IDX] | (|ser0_err);
    ev[`ITVD_SER1_ERR_IDX] = src_event[`ITVD_SER1_ERR_IDX] | (|ser1_err);
  end

  for (genvar g = 0; g < NSRC; g++) begin : g_src
    itvd_src_ctrl u_src (
      .hclk(hclk),
      .hresetn(hresetn),
      .wr_en(wr_src[g]),
      .wr_data(hwdata[7:0]),
      .set_evt(ev[g]),
      .clr_serv(clr_src[g]),
      .icr(icr[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // round of prioritisation: highest level, then group, then lowest index
  always_comb begin
    found = 1'b0;
    best_idx = '0;
    best_lvl = 4'h0;
    best_grp = 2'h0;
    for (int i = 0; i < NSRC; i++) begin
      if (icr[i].req && icr[i].en &&
          (!found || {icr[i].lvl, icr[i].grp} > {best_lvl, best_grp})) begin
        found = 1'b1;
        best_idx = SW'(i);
        best_lvl = icr[i].lvl;
        best_grp = icr[i].grp;
      end
    end
  end
  // channel picked by the low level bit and the group, top two levels only
  assign best_chn = CW'({best_lvl[0], best_grp});
  assign hold_flash = flash_busy && flash_code_seg0;
  assign serve = found && psw_ien_r && (best_lvl > psw_lvl_r) &&
                 round_tick && !hold_flash && !hw_go && !sw_go &&
                 (state_r == itvd_pkg::ITVD_ST_RUN);
  // an exhausted channel falls back to a normal interrupt
  assign as_pec = (best_lvl >= `ITVD_PEC_LVL_LO) &&
                  (chn_r[best_chn][`ITVD_CHN_CNT_LSB +: 8] != 8'h00);
  // clear the winner on entry, but keep it when its count runs out
  always_comb begin
    clr_src = '0;
    if (serve && !(as_pec && chn_r[best_chn][`ITVD_CHN_CNT_LSB +: 8] == 8'h01)) begin
      clr_src[best_idx] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // hardware trap capture; the nmi pin traps when it turns active
  assign nmi_rise = nmi_pin && !nmi_q_r;
  assign tset = {|fault_b, stk_unf, stk_ovf, nmi_rise};
  assign hw_go = |tpend_r;
  assign sw_go = sw_pend_r && !hw_go;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nmi_q_r <= 1'b0;
    end else begin
      nmi_q_r <= nmi_pin;
    end
  end
  // pending traps: one served per cycle, nmi first; new events win
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tpend_r <= 4'h0;
    end else begin
      for (int t = 0; t < 4; t++) begin
        if (tset[t]) begin
          tpend_r[t] <= 1'b1;
        end else if (hw_go && (tpend_r & ((4'h1 << t) - 4'h1)) == 4'h0) begin
          tpend_r[t] <= 1'b0;
        end
      end
    end
  end
  // trap flags for software; a hardware set beats a software clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tfr_r <= `ITVD_TFR_RESET;
    end else begin
      tfr_r <= (wr_tfr ? hwdata[7:0] : tfr_r) |
               {fault_b, stk_unf, stk_ovf, nmi_rise};
    end
  end
  // software trap held until hardware traps have gone
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sw_pend_r <= 1'b0;
      sw_num_r <= 7'h00;
    end else if (swtrap_valid) begin
      sw_pend_r <= 1'b1;
      sw_num_r <= swtrap_num;
    end else if (sw_go) begin
      sw_pend_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status word: software sets both; normal interrupt entry raises the cpu level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      psw_lvl_r <= 4'(`ITVD_PSW_RESET);
      psw_ien_r <= 1'b0;
    end else if (wr_psw) begin
      psw_lvl_r <= hwdata[`ITVD_PSW_LVL_LSB +: 4];
      psw_ien_r <= hwdata[`ITVD_PSW_IEN_BIT];
    end else if (serve && !as_pec) begin
      psw_lvl_r <= best_lvl;
    end
  end
  // channel control: count decrements once per transfer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int c = 0; c < NCHN; c++) begin
        chn_r[c] <= `ITVD_CHN_RESET;
      end
    end else begin
      for (int c = 0; c < NCHN; c++) begin
        if (wr_chn[c]) begin
          chn_r[c] <= hwdata[8:0];
        end else if (serve && as_pec && best_chn == CW'(c)) begin
          chn_r[c][`ITVD_CHN_CNT_LSB +: 8] <= chn_r[c][`ITVD_CHN_CNT_LSB +: 8] - 8'h01;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // stall for the one instruction cycle of a channel transfer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= itvd_pkg::ITVD_ST_RUN;
    end else begin
      case (state_r)
        itvd_pkg::ITVD_ST_RUN: begin
          if (serve && as_pec) begin
            state_r <= itvd_pkg::ITVD_ST_PEC;
          end
        end
        itvd_pkg::ITVD_ST_PEC: begin
          if (round_tick) begin
            state_r <= itvd_pkg::ITVD_ST_RUN;
          end
        end
        default: begin
          state_r <= itvd_pkg::ITVD_ST_RUN;
        end
      endcase
    end
  end
  assign cpu_stall = (state_r == itvd_pkg::ITVD_ST_PEC);
  // dispatch word: one cycle pulse; vectors sit low in segment zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      disp_r <= '0;
    end else begin
      disp_r.valid <= hw_go || sw_go || serve;
      disp_r.push_status <= hw_go || sw_go || (serve && !as_pec);
      disp_r.channel <= 3'h0;
      disp_r.byte_mode <= 1'b0;
      disp_r.level <= psw_lvl_r;
      if (hw_go) begin
        disp_r.kind <= itvd_pkg::ITVD_K_HWTRAP;
        if (tpend_r[0]) begin
          disp_r.vector <= `ITVD_VEC_NMI;
        end else if (tpend_r[1]) begin
          disp_r.vector <= `ITVD_VEC_STKOF;
        end else if (tpend_r[2]) begin
          disp_r.vector <= `ITVD_VEC_STKUF;
        end else begin
          disp_r.vector <= `ITVD_VEC_CLASSB;
        end
      end else if (sw_go) begin
        disp_r.kind <= itvd_pkg::ITVD_K_SWTRAP;
        disp_r.vector <= {7'h00, sw_num_r, 2'h0};
      end else if (serve && as_pec) begin
        disp_r.kind <= itvd_pkg::ITVD_K_PEC;
        disp_r.vector <= 16'h0000;
        disp_r.channel <= 3'(best_chn);
        disp_r.byte_mode <= chn_r[best_chn][`ITVD_CHN_BYTE_BIT];
        disp_r.level <= best_lvl;
      end else if (serve) begin
        disp_r.kind <= itvd_pkg::ITVD_K_INT;
        // serial sources land at A8h..BCh by this same sum
        disp_r.vector <= {7'h00, `ITVD_SRC_TRAPNUM_BASE + 7'(best_idx), 2'h0};
        disp_r.level <= best_lvl;
      end else begin
        disp_r.kind <= itvd_pkg::ITVD_K_NONE;
      end
    end
  end
  assign disp = disp_r;
endmodule : itvd_dispatch

// ==== tb/itvd_dispatch_assertions.sv ====
// itvd_dispatch_assertions.sv: port checker for the dispatch block
// assumes: bound to itvd_dispatch, one clock, async active-low reset
`timescale 1ns/10ps
`include "itvd_map.svh"
module itvd_dispatch_chk #(
  parameter int NCLSB = 5
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic round_tick,
  input wire logic nmi_pin,
  input wire logic stk_ovf,
  input wire logic stk_unf,
  input wire logic [NCLSB-1:0] fault_b,
  input wire logic swtrap_valid,
  input wire logic [6:0] swtrap_num,
  input wire logic flash_busy,
  input wire logic flash_code_seg0,
  input itvd_pkg::itvd_disp_t disp,
  input wire logic cpu_stall
);
  default clocking dcb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // any hardware trap cause this cycle; guards the software trap timing
  wire logic hw_any = nmi_pin | stk_ovf | stk_unf | (|fault_b);
  wire logic is_pec = disp.valid && disp.kind == itvd_pkg::ITVD_K_PEC;
  wire logic is_int = disp.valid && disp.kind == itvd_pkg::ITVD_K_INT;
  ////////////////////////////////////////
  // a hardware trap entry with its vector
  sequence s_hw(logic [15:0] v);
    disp.valid && disp.push_status && disp.kind == itvd_pkg::ITVD_K_HWTRAP && disp.vector == v;
  endsequence
  // one wait cycle, then data
  sequence s_rd_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  AST_READ_WAIT: assert property (hsel && htrans[1] && hready && !hwrite |=> s_rd_wait)
    else $error("read data phase wait wrong");
  AST_HRESP_OKAY: assert property (hresp == 1'b0)
    else $error("response not okay");
  AST_NMI_TRAP: assert property ($rose(nmi_pin) |-> ##2 s_hw(`ITVD_VEC_NMI))
    else $error("nmi trap not taken");
  AST_CLASSB_VEC: assert property ((|fault_b) && !nmi_pin && !stk_ovf && !stk_unf |-> ##2 s_hw(`ITVD_VEC_CLASSB))
    else $error("class b vector wrong");
  AST_SW_TRAP: assert property (swtrap_valid && !hw_any |-> ##2 disp.valid && disp.push_status &&
    disp.kind == itvd_pkg::ITVD_K_SWTRAP && disp.vector == {7'h00, $past(swtrap_num, 2), 2'b00})
    else $error("software trap vector wrong");
  AST_PUSH: assert property (disp.valid && !is_pec |-> disp.push_status)
    else $error("status not pushed");
  AST_PEC_ENTRY: assert property (is_pec |-> !disp.push_status && cpu_stall && disp.level[3:1] == 3'b111)
    else $error("transfer entry wrong");
  AST_STALL_CAUSE: assert property ($rose(cpu_stall) |-> is_pec)
    else $error("stall without transfer");
  AST_STALL_LEN: assert property (cpu_stall && round_tick |-> ##[1:2] !cpu_stall)
    else $error("stall too long");
  AST_FLASH_HOLD: assert property (flash_busy && flash_code_seg0 && round_tick |=> !is_int && !is_pec)
    else $error("served during flash write");
  AST_INT_RANGE: assert property (is_int |-> disp.vector >= 16'h0040 && disp.vector <= 16'h00bc &&
    disp.vector[1:0] == 2'b00)
    else $error("interrupt vector out of table");
endmodule : itvd_dispatch_chk

bind itvd_dispatch itvd_dispatch_chk #(.NCLSB(NCLSB)) u_chk (.hclk, .hresetn, .hsel, .htrans, .hwrite,
  .hready, .hreadyout, .hresp, .round_tick, .nmi_pin, .stk_ovf, .stk_unf, .fault_b, .swtrap_valid,
  .swtrap_num, .flash_busy, .flash_code_seg0, .disp, .cpu_stall);

// ==== tb/itvd_core_model.sv ====
// itvd_core_model.sv: cpu core side, marks instruction cycles, takes dispatches
// assumes: same clock and reset as the dispatch block
`timescale 1ns/10ps
module itvd_core_model (
  input wire logic hclk,
  input wire logic hresetn,
  input itvd_pkg::itvd_disp_t disp,
  input wire logic cpu_stall,
  output logic round_tick,
  output logic [7:0] n_pec
);
  logic [1:0] cyc_r;
  // four clocks an instruction cycle; keeps ticking while stalled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cyc_r <= 2'h0;
    end else begin
      cyc_r <= cyc_r + 2'h1;
    end
  end
  assign round_tick = (cyc_r == 2'h3);
  // counts channel moves; the data move itself is not modelled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      n_pec <= 8'h00;
    end else if (disp.valid && disp.kind == itvd_pkg::ITVD_K_PEC && cpu_stall) begin
      n_pec <= n_pec + 8'h01;
    end
  end
endmodule : itvd_core_model

// ==== tb/testbench.sv ====
// testbench.sv: self-checking bench for the dispatch block
// assumes: core model makes round_tick; bus master is this bench
`timescale 1ns/10ps
module testbench;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0, hwrite = 1'b0, nmi_pin = 1'b0, stk_ovf = 1'b0, stk_unf = 1'b0;
  logic swtrap_valid = 1'b0, flash_busy = 1'b0, flash_code_seg0 = 1'b0;
  logic hready, hreadyout, hresp, round_tick, cpu_stall;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, src_event = 32'h0, hrdata, q, r;
  logic [2:0] ser0_err = 3'h0, ser1_err = 3'h0;
  logic [4:0] fault_b = 5'h00;
  logic [6:0] swtrap_num = 7'h00;
  logic [7:0] n_pec;
  itvd_pkg::itvd_disp_t disp;
  int bad_count = 0, n_tests = 0, k;
  // rows: source index, level, event kind (0 line, 1 serial0 error, 2 serial1 error), vector
  logic [31:0] rows [8] = '{32'h0030_0040, 32'h0590_0054, 32'h1a10_00a8, 32'h1bf0_00ac,
    32'h1c41_00b0, 32'h1dc0_00b4, 32'h1e20_00b8, 32'h1f62_00bc};
  assign hready = hreadyout;
  always #25 hclk = ~hclk;
  itvd_dispatch u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hready, .hwdata,
    .hrdata, .hreadyout, .hresp, .round_tick, .src_event, .ser0_err, .ser1_err, .nmi_pin, .stk_ovf,
    .stk_unf, .fault_b, .swtrap_valid, .swtrap_num, .flash_busy, .flash_code_seg0, .disp, .cpu_stall);
  itvd_core_model u_core (.hclk, .hresetn, .disp, .cpu_stall, .round_tick, .n_pec);
  ////////////////////////////////////////
  task print_verdict;
    $display("checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // bounded wait for a flag sampled at the rising edge; a hang ends the run
  task wait_on(input int sel, input int lim);
    for (int i = 0; i < lim; i++) begin
      @(posedge hclk);
      if ((sel == 0 ? hready : disp.valid) === 1'b1) return;
    end
    bad_count++;
    $display("wrong value wait: expected 1 seen 0");
    print_verdict;
  endtask : wait_on
  // single word transfer; the address phase holds until hready is seen high
  task ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h0, a};
    hwrite <= w;
    wait_on(0, 9);
    htrans <= 2'h0;
    hwdata <= d;
    wait_on(0, 9);
    q = hrdata;
    hsel <= 1'b0;
  endtask : ahb
  // one-cycle pulse on a source line
  task pulse_src(input int i);
    @(posedge hclk);
    src_event[i] <= 1'b1;
    @(posedge hclk);
    src_event <= 32'h0;
  endtask : pulse_src
  task chk_disp(input itvd_pkg::itvd_kind_t kd, input logic [15:0] v);
    wait_on(1, 40);
    chk("kind", 32'(kd), 32'(disp.kind));
    chk("vector", 32'(v), 32'(disp.vector));
  endtask : chk_disp
  // far-side watchdog in case every bounded wait is bypassed
  initial begin
    #5000000;
    bad_count++;
    print_verdict;
  end
  ////////////////////////////////////////
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    chk("reset disp", 32'h0, 32'(disp));
    chk("reset stall", 32'h0, 32'(cpu_stall));
    ahb(0, 12'hffc, 32'h0);
    chk("unmapped", 32'h0, q);
    ahb(0, 12'h080, 32'h0);
    chk("reset status", 32'h0, q);
    $display("test reset done");
    // plain interrupts, one per row
    for (k = 0; k < 8; k++) begin
      r = rows[k];
      ahb(1, {2'h0, r[31:24], 2'h0}, {24'h0, 2'h1, r[23:20], 2'h0});
      ahb(1, 12'h080, 32'h10);
      @(posedge hclk);
      if (r[19:16] == 4'h0) src_event[r[28:24]] <= 1'b1;
      ser0_err <= (r[19:16] == 4'h1) ? 3'h4 : 3'h0;
      ser1_err <= (r[19:16] == 4'h2) ? 3'h1 : 3'h0;
      @(posedge hclk);
      src_event <= 32'h0;
      ser0_err <= 3'h0;
      ser1_err <= 3'h0;
      chk_disp(itvd_pkg::ITVD_K_INT, r[15:0]);
      chk("push", 32'h1, 32'(disp.push_status));
      ahb(0, {2'h0, r[31:24], 2'h0}, 32'h0);
      chk("ctrl after entry", {24'h0, 2'h1, r[23:20], 2'h0}, q);
      ahb(1, {2'h0, r[31:24], 2'h0}, 32'h0);
    end
    $display("test vectors done");
    // level against cpu level: 9 and 5 held at cpu level 9
    ahb(1, 12'h008, 32'h54);
    ahb(1, 12'h00c, 32'h64);
    ahb(1, 12'h080, 32'h19);
    @(posedge hclk);
    src_event <= 32'hc;
    @(posedge hclk);
    src_event <= 32'h0;
    repeat (16) @(posedge hclk) chk("held", 32'h0, 32'(disp.valid));
    ahb(1, 12'h080, 32'h14);
    chk_disp(itvd_pkg::ITVD_K_INT, 16'h004c);
    ahb(1, 12'h080, 32'h10);
    chk_disp(itvd_pkg::ITVD_K_INT, 16'h0048);
    $display("test levels done");
    // channel transfers: count 2 byte mode, source 4 at level 14
    ahb(1, 12'h0a0, 32'h102);
    ahb(1, 12'h010, 32'h78);
    ahb(1, 12'h080, 32'h10);
    pulse_src(4);
    chk_disp(itvd_pkg::ITVD_K_PEC, 16'h0000);
    chk("chan", 32'h8, {28'h0, disp.byte_mode, disp.channel});
    chk("stall", 32'h1, 32'(cpu_stall));
    ahb(0, 12'h0a0, 32'h0);
    chk("count", 32'h101, q);
    ahb(0, 12'h010, 32'h0);
    chk("flag after move", 32'h78, q);
    pulse_src(4);
    chk_disp(itvd_pkg::ITVD_K_PEC, 16'h0000);
    chk_disp(itvd_pkg::ITVD_K_INT, 16'h0050);
    chk("moves", 32'h2, 32'(n_pec));
    $display("test transfers done");
    // nmi beats a pending interrupt
    ahb(1, 12'h080, 32'h10);
    @(posedge hclk);
    nmi_pin <= 1'b1;
    src_event[4] <= 1'b1;
    @(posedge hclk);
    src_event <= 32'h0;
    chk_disp(itvd_pkg::ITVD_K_HWTRAP, 16'h0008);
    chk_disp(itvd_pkg::ITVD_K_INT, 16'h0050);
    nmi_pin <= 1'b0;
    ahb(0, 12'h084, 32'h0);
    chk("nmi flag", 32'h1, q);
    // stack traps, then each class b cause
    for (k = 0; k < 7; k++) begin
      ahb(1, 12'h084, 32'h0);
      @(posedge hclk);
      stk_ovf <= (k == 0);
      stk_unf <= (k == 1);
      fault_b <= (k > 1) ? 5'(1 << (k - 2)) : 5'h00;
      @(posedge hclk);
      {stk_ovf, stk_unf, fault_b} <= 7'h00;
      chk_disp(itvd_pkg::ITVD_K_HWTRAP, (k == 0) ? 16'h0010 : (k == 1) ? 16'h0018 : 16'h0028);
      chk("push", 32'h1, 32'(disp.push_status));
      ahb(0, 12'h084, 32'h0);
      chk("trap flags", 32'(1 << (k + 1)), q);
    end
    $display("test traps done");
    // software traps at the table top (7Fh) and at number 05h
    for (k = 0; k < 2; k++) begin
      @(posedge hclk);
      swtrap_valid <= 1'b1;
      swtrap_num <= (k == 0) ? 7'h7f : 7'h05;
      @(posedge hclk);
      swtrap_valid <= 1'b0;
      chk_disp(itvd_pkg::ITVD_K_SWTRAP, (k == 0) ? 16'h01fc : 16'h0014);
    end
    // last dispatch register keeps the vector, kind drops back to none
    ahb(0, 12'h088, 32'h0);
    chk("last dispatch", 32'h0000_0014, q);
    $display("test software traps done");
    // flash write holds service, request stays latched
    ahb(1, 12'h080, 32'h10);
    flash_busy <= 1'b1;
    flash_code_seg0 <= 1'b1;
    pulse_src(4);
    repeat (16) @(posedge hclk) chk("flash hold", 32'h0, 32'(disp.valid));
    ahb(0, 12'h010, 32'h0);
    chk("latched", 32'hf8, q);
    flash_busy <= 1'b0;
    chk_disp(itvd_pkg::ITVD_K_INT, 16'h0050);
    $display("test flash hold done");
    // reset in mid-run: cpu level, control and dispatch word go back to zero
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    chk("mid reset stall", 32'h0, 32'(cpu_stall));
    hresetn <= 1'b1;
    chk("mid reset disp", 32'h0, 32'(disp));
    ahb(0, 12'h080, 32'h0);
    chk("mid reset status", 32'h0, q);
    ahb(0, 12'h010, 32'h0);
    chk("mid reset ctrl", 32'h0, q);
    $display("test mid reset done");
    print_verdict;
  end
endmodule : testbench
